// >>> rpc_regs.svh
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH
// number of flip-flops in each pin synchroniser
`define RPC_SYNC_STAGES 2
// regulator state while the supply is held in reset
`define RPC_EN_RESET 1'h0
// pin synchroniser reset values: the idle levels of the two pins
`define RPC_PUB_IDLE 1'h1
`define RPC_TRST_IDLE 1'h0
`endif

// >>> rpc_pkg.sv
package rpc_pkg;
	typedef enum logic [1:0] {
		RPC_OFF,
		RPC_NORMAL,
		RPC_STANDBY
	} rpc_mode_e;
endpackage

// >>> rpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; the first stage feeds only the second
module rpc_sync #(
	parameter logic RESET_VAL = 1'h0
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta <= RESET_VAL;
			q_o  <= RESET_VAL;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule
`default_nettype wire

// >>> rpc_power_control.sv
// Overview of operation
// R1: power-up bar pin low keeps the regulator enabled regardless of other sources.
// R2: test reset pin high keeps the regulator enabled regardless of other sources.
// R3: request 1 enables; request 0 disables only with pin high and test reset low.
// R4: initial-state input sets regulator state when the supply first comes up.
// R5: a rising edge on the counter wake match turns the regulator on.
// R6: core power-up output is the inverse of the power-up bar pin.
// R7: core-powered indication is 1 while the core is powered.
// R8: regulator enable output 1 switches regulator on, 0 switches it off.
// R9: with test reset high or pin low, stay in normal operation.
// R10: controller runs normally, arms counter, loads match, then drops the request.
// R11: controller sets wake-on-match so the counter match ends standby.
// R12: counter match and wake match follow equality only when wake-on-match is set.
// R13: regulator enable is held state, set and cleared as the sources allow.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_regs.svh"
module rpc_power_control
	import rpc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic power_up_bar_pin_i,
	input  wire logic test_reset_pin_i,
	input  wire logic regulator_power_up_request_i,
	input  wire logic regulator_initial_state_i,
	input  wire logic counter_equal_i,
	input  wire logic wake_on_match_enable_i,
	output logic      counter_match_out_o,
	output logic      core_power_up_out_o,
	output logic      core_powered_ok_o,
	output logic      regulator_enable_out_o,
	output rpc_mode_e power_state_monitor_o
);
	localparam int PIN_COUNT = 2;
	// bit 0 carries the power-up bar pin, bit 1 the test reset pin
	localparam logic [PIN_COUNT-1:0] PIN_IDLE = {`RPC_TRST_IDLE, `RPC_PUB_IDLE};

	wire  [PIN_COUNT-1:0] pin_raw = {test_reset_pin_i, power_up_bar_pin_i};
	wire  [PIN_COUNT-1:0] pin_s;
	logic                 init_done;
	logic                 wake_d;
	logic                 reg_en;
	rpc_mode_e            idle_mode;

	// pins come from outside the clock domain; each passes two flops before use, except the raw power-up bar pin inverted onto the core power-up output
	// syncs reset to the idle levels so no forcing term appears out of reset
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1)
		begin : g_pin_sync
			rpc_sync #(
				.RESET_VAL (PIN_IDLE[g])
			) u_sync (
				.clk_i   (clk_i),
				.rst_b_i (rst_b_i),
				.d_i     (pin_raw[g]),
				.q_o     (pin_s[g])
			);
		end
	endgenerate

	wire pub_s  = pin_s[0];
	wire trst_s = pin_s[1];

	// the counter match is gated so nothing leaks out while wake-on-match is off
	wire wake_match  = counter_equal_i & wake_on_match_enable_i; // R12
	wire wake_rise   = wake_match & ~wake_d; // R5
	wire forced_on   = ~pub_s | trst_s; // R1 R2 R9
	// a drop is allowed only when neither pin forces the regulator on
	wire may_clear   = ~regulator_power_up_request_i & ~forced_on; // R3
	wire set_cause   = wake_rise | regulator_power_up_request_i; // R3 R5
	// set beats clear so a wake landing together with a drop is never lost
	wire next_reg_en = !init_done ? regulator_initial_state_i : // R4
		set_cause ? 1'h1 : // R3 R5
		may_clear ? 1'h0 : reg_en; // R13
	wire pub_pin_b   = ~power_up_bar_pin_i; // R6

	// the strap is read on the first edge after the supply comes up, never again
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			init_done <= 1'h0;
		else
			init_done <= 1'h1; // R4
	end

	// reset low equals the gated match while wake-on-match is off: no false edge
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			wake_d <= 1'h0;
		else
			wake_d <= wake_match; // R5
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			reg_en <= `RPC_EN_RESET;
		else
			reg_en <= next_reg_en; // R13
	end

	// forcing terms are ORed in directly so a pin acts without waiting on the flop
	assign idle_mode              = wake_on_match_enable_i ? RPC_STANDBY : RPC_OFF;
	assign regulator_enable_out_o = reg_en | forced_on; // R1 R2 R8
	// the core only runs while the regulator is on, so the flag mirrors the enable
	assign core_powered_ok_o      = regulator_enable_out_o; // R7
	assign core_power_up_out_o    = pub_pin_b; // R6
	assign counter_match_out_o    = wake_match; // R12
	assign power_state_monitor_o  = (forced_on | reg_en) ? RPC_NORMAL : idle_mode; // R9

	// pin checks look two edges back, matching the synchroniser delay
	pub_forces_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
		$past(init_done) && !$past(power_up_bar_pin_i, `RPC_SYNC_STAGES)
		|-> regulator_enable_out_o)
		else $error("regulator off while power-up bar pin low");

	trst_forces_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
		$past(init_done) && $past(test_reset_pin_i, `RPC_SYNC_STAGES)
		|-> regulator_enable_out_o)
		else $error("regulator off while test reset pin high");

	trst_normal_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
		trst_s
		|-> power_state_monitor_o == RPC_NORMAL)
		else $error("not normal while test reset high");

	pub_normal_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
		!pub_s
		|-> power_state_monitor_o == RPC_NORMAL)
		else $error("not normal while power-up bar pin low");

	request_drop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
		init_done && may_clear && !wake_rise
		|=> !reg_en)
		else $error("request drop ignored");

	request_on_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
		init_done && regulator_power_up_request_i
		|=> regulator_enable_out_o)
		else $error("request did not enable");

	init_state_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
		!init_done
		|=> reg_en == $past(regulator_initial_state_i))
		else $error("initial state not taken");

	reset_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
		!init_done && !forced_on
		|-> !regulator_enable_out_o)
		else $error("regulator on before the strap was taken");

	strap_once_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
		init_done
		|=> init_done)
		else $error("strap window reopened");

	wake_edge_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
		init_done && $rose(wake_match)
		|=> reg_en)
		else $error("wake edge did not enable");

	standby_wake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
		init_done && power_state_monitor_o == RPC_STANDBY && $rose(counter_match_out_o)
		|=> regulator_enable_out_o)
		else $error("standby not left on wake match");

	pub_invert_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
		1'h1
		|-> core_power_up_out_o != power_up_bar_pin_i)
		else $error("core power-up not inverse of pin");

	good_follows_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
		1'h1
		|-> core_powered_ok_o == regulator_enable_out_o)
		else $error("powered indication wrong");

	en_normal_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
		regulator_enable_out_o
		|-> power_state_monitor_o == RPC_NORMAL)
		else $error("regulator on but mode not normal");

	off_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
		!regulator_enable_out_o
		|-> power_state_monitor_o != RPC_NORMAL)
		else $error("regulator off but mode normal");

	monitor_legal_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
		1'h1
		|-> power_state_monitor_o inside {RPC_OFF, RPC_NORMAL, RPC_STANDBY})
		else $error("mode outside the defined codes");

	forced_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
		init_done && forced_on && reg_en
		|=> reg_en)
		else $error("regulator state dropped while a pin forces it");

	match_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
		!wake_on_match_enable_i
		|-> !counter_match_out_o)
		else $error("match out while wake-on-match off");

	match_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
		wake_on_match_enable_i
		|-> counter_match_out_o == counter_equal_i)
		else $error("match out does not follow equality");

	wake_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
		init_done && !wake_on_match_enable_i && !regulator_power_up_request_i
		|=> !$rose(reg_en))
		else $error("regulator woke with wake-on-match off");

	hold_state_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
		init_done && !may_clear && !wake_rise && !regulator_power_up_request_i
		|=> reg_en == $past(reg_en))
		else $error("regulator state changed without cause");

	clear_cause_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
		init_done && $fell(reg_en)
		|-> $past(may_clear))
		else $error("regulator state cleared without a drop");

	rise_cause_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
		$past(init_done) && $rose(reg_en)
		|-> $past(set_cause))
		else $error("regulator state set without a cause");
endmodule
`default_nettype wire

// >>> rpc_wake_model.sv
`timescale 1ns/1ps
`default_nettype none
// free-running counter; equality pulses one cycle in sixteen
module rpc_wake_model (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [3:0] match_value_i,
	output logic            counter_equal_o
);
	logic [3:0] count;
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			count <= 4'h0;
		else
			count <= count + 4'h1;
	assign counter_equal_o = (count == match_value_i);
endmodule
`default_nettype wire

// >>> core_regulator_power_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module core_regulator_power_control_tb;
	import rpc_pkg::*;
	logic       clk = 1'h0, rst_b = 1'h0, power_up_bar_pin = 1'h1, trst = 1'h0;
	logic       req = 1'h0, init = 1'h0, wen = 1'h0;
	logic [3:0] mv = 4'h9;
	logic [1:0] mh = 2'h0;
	logic       eq, cmo, cpu, ok, en;
	rpc_mode_e  mon;
	int         miscompares = 0, checks_done = 0, seed = 30555;
	initial forever #20 clk = ~clk;
	// wake term history as the design sampled it on the last two edges
	always @(posedge clk) mh <= {mh[0], eq & wen};
	rpc_wake_model pm (.clk_i(clk), .rst_b_i(rst_b), .match_value_i(mv), .counter_equal_o(eq));
	rpc_power_control dut (.clk_i(clk), .rst_b_i(rst_b), .power_up_bar_pin_i(power_up_bar_pin),
		.test_reset_pin_i(trst), .regulator_power_up_request_i(req),
		.regulator_initial_state_i(init), .counter_equal_i(eq), .wake_on_match_enable_i(wen),
		.counter_match_out_o(cmo), .core_power_up_out_o(cpu), .core_powered_ok_o(ok),
		.regulator_enable_out_o(en), .power_state_monitor_o(mon));
	task chk(input logic seen, input logic want);
		checks_done++;
		if (seen !== want)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task results;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// a wake rise on the last edge wins over a clear on that same edge
	function automatic logic want_en();
		return req | !power_up_bar_pin | trst | (mh[0] & !mh[1]);
	endfunction
	// with the regulator off the mode tells standby from off by wake-on-match
	function automatic rpc_mode_e want_mon();
		if (want_en())
			return RPC_NORMAL;
		return wen ? RPC_STANDBY : RPC_OFF;
	endfunction
	task outs;
		chk(cpu, !power_up_bar_pin);
		chk(cmo, eq & wen);
		chk(ok, want_en());
		chk(en, want_en());
		chk(mon == want_mon(), 1'h1);
	endtask
	initial
	begin
		// generous: the sequence needs at most about 830 cycles
		#400000;
		miscompares++;
		results();
	end
	initial
	begin
		for (int i = 0; i < 2; i++)
		begin
			rst_b = 0;
			init = i[0];
			repeat (2) @(negedge clk);
			rst_b = 1;
			@(negedge clk);
			chk(en, init);
		end
		req = 1;
		wen = 1;
		repeat (3) @(negedge clk);
		req = 0;
		@(negedge clk);
		while (eq) @(negedge clk);
		@(negedge clk);
		chk(en, 1'h0);
		chk(mon == RPC_STANDBY, 1'h1);
		while (!eq) @(negedge clk);
		@(negedge clk);
		chk(en, 1'h1);
		chk(mon == RPC_NORMAL, 1'h1);
		repeat (200)
		begin
			{power_up_bar_pin, trst, req, wen} = 4'($random(seed));
			mv = 4'($random(seed));
			// pins need two edges through the synchroniser, a clear one more
			repeat (4) @(negedge clk);
			outs();
		end
		results();
	end
endmodule
`default_nettype wire
